// [pkg/tms_pkg.sv]
package tms_pkg;
   // ==========================================
   // Clock and action timing
   localparam int          CLK_MHZ    = 250;     // Core clock rate
   localparam int          BREAK_NS   = 1000;    // Relay open time
   localparam int          SETTLE_NS  = 2000;    // Relay close settle
   localparam int          BREAK_CYC  = (BREAK_NS * CLK_MHZ + 999) / 1000;
   localparam int          SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [15:0] BREAK_CNT  = 16'(BREAK_CYC);
   localparam logic [15:0] SETTLE_CNT = 16'(SETTLE_CYC);

   // ==========================================
   // Register offsets
   localparam logic [4:0] A_CTRL   = 5'h00;      // Mode and commands
   localparam logic [4:0] A_SRC    = 5'h04;      // Layer sources
   localparam logic [4:0] A_ARMN   = 5'h08;      // Arm layer count
   localparam logic [4:0] A_SCANN  = 5'h0C;      // Scan layer count
   localparam logic [4:0] A_MEASN  = 5'h10;      // Measure layer count
   localparam logic [4:0] A_TIMER  = 5'h14;      // Timer interval
   localparam logic [4:0] A_STAT   = 5'h18;      // Live state

   // ==========================================
   // Control fields
   localparam int B_ADV   = 0;                   // Advanced model
   localparam int B_CONT  = 1;                   // Basic continuous
   localparam int B_INIT  = 2;                   // Initiate, write-only
   localparam int B_ABORT = 3;                   // Abort, write-only
   localparam int B_SCAN  = 4;                   // Scanner enable
   localparam int B_FUNC  = 5;                   // Function change
   localparam int F_ARM   = 0;                   // Source field lsbs
   localparam int F_SCAN  = 3;
   localparam int F_MANUAL_FIRE_KEY  = 6;

   // ==========================================
   // Reset values
   localparam logic [5:0]  CTRL_RST  = 6'h01;    // Advanced mode
   localparam logic [8:0]  SRC_RST   = 9'h000;   // All immediate
   localparam logic [15:0] CNT_RST   = 16'h0000; // Zero means infinite
   localparam logic [15:0] TIMER_RST = 16'h0100;

   // Control source selections
   typedef enum logic [2:0] {
      SRC_IMM, SRC_EXT, SRC_MAN, SRC_BUS, SRC_LINK, SRC_TIMER, SRC_HOLD
   } tms_src_e;
endpackage : tms_pkg

// [verilog/tms_sequencer.sv]
`timescale 1ns/1ps
module tms_sequencer
   import tms_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [4:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   input  wire logic        i_manual_fire_key,
   input  wire logic        i_external_fire_input,
   input  wire logic        i_bus_trigger,
   input  wire logic        i_bus_init,
   input  wire logic        i_link_bus_source,
   input  wire logic        i_meas_done,
   output logic             o_armed,
   output logic             o_relay_open,
   output logic             o_relay_close,
   output logic      [3:0]  o_channel,
   output logic             o_func_change,
   output logic             o_meas_start,
   output logic             o_out_manual_fire_key
);
   // ==========================================
   // State
   typedef enum logic [3:0] {
      ST_IDLE, ST_ARM, ST_SCAN, ST_MANUAL_FIRE_KEY, ST_ACT,
      ST_BRK, ST_SETL, ST_MEAS, ST_OUT
   } tms_state_e;

   tms_state_e  state_q, state_d;   // Sequencer position
   logic [5:0]  ctrl_q, ctrl_d;     // Stored control bits
   logic [8:0]  src_q, src_d;       // Three source fields
   logic [15:0] armn_q, armn_d;     // Layer limits
   logic [15:0] scann_q, scann_d;
   logic [15:0] measn_q, measn_d;
   logic [15:0] tmr_q, tmr_d;       // Timer interval
   logic [15:0] armc_q, armc_d;     // Layer pass counters
   logic [15:0] scanc_q, scanc_d;
   logic [15:0] measc_q, measc_d;
   logic [15:0] tcnt_q, tcnt_d;     // Timer elapsed count
   logic        tfirst_q, tfirst_d; // Timer first pass pending
   logic [15:0] dly_q, dly_d;       // Relay delay count
   logic        armed_q, armed_d;
   logic        ropen_q, ropen_d;
   logic        rclose_q, rclose_d;
   logic [3:0]  chan_q, chan_d;
   logic        func_q, func_d;
   logic        mstart_q, mstart_d;
   logic        otrig_q, otrig_d;
   logic [31:0] rdata_q, rdata_d;

   // Decoded command strobes
   logic        wr_ctrl, init_w, abort_w, adv;
   tms_src_e    cur_src;           // Source of the waiting layer
   logic        hit;               // Waiting layer satisfied

   assign adv     = ctrl_q[B_ADV];
   assign wr_ctrl = i_wr && (i_addr == A_CTRL);
   assign init_w  = wr_ctrl && i_wdata[B_INIT];
   assign abort_w = wr_ctrl && i_wdata[B_ABORT];

   // ==========================================
   // Event detection for the waiting layer
   always_comb begin
      case (state_q)
         ST_ARM:  cur_src = tms_src_e'(src_q[F_ARM +: 3]);
         ST_SCAN: cur_src = tms_src_e'(src_q[F_SCAN +: 3]);
         default: cur_src = tms_src_e'(src_q[F_MANUAL_FIRE_KEY +: 3]);
      endcase
      case (cur_src)
         SRC_IMM:  hit = 1'b1;
         SRC_EXT:  hit = i_external_fire_input;
         SRC_MAN:  hit = i_manual_fire_key;
         SRC_BUS:  hit = i_bus_trigger;
         // Link and hold fall back to immediate in basic mode
         SRC_LINK: hit = adv ? i_link_bus_source : 1'b1;
         // Arm layer cannot use the timer; it acts as immediate
         SRC_TIMER: hit = (state_q == ST_ARM) || tfirst_q || (tcnt_q >= tmr_q);
         SRC_HOLD: hit = !adv;
         default:  hit = 1'b1;
      endcase
   end

   // ==========================================
   // Next-state logic for the whole sequencer
   always_comb begin
      state_d  = state_q;
      ctrl_d   = ctrl_q;
      src_d    = src_q;
      armn_d   = armn_q;
      scann_d  = scann_q;
      measn_d  = measn_q;
      tmr_d    = tmr_q;
      armc_d   = armc_q;
      scanc_d  = scanc_q;
      measc_d  = measc_q;
      tfirst_d = tfirst_q;
      dly_d    = dly_q;
      armed_d  = armed_q;
      chan_d   = chan_q;
      ropen_d  = 1'b0;
      rclose_d = 1'b0;
      func_d   = 1'b0;
      mstart_d = 1'b0;
      otrig_d  = 1'b0;
      // Timer counts freely and saturates, so a long wait is safe
      tcnt_d   = (tcnt_q == 16'hFFFF) ? tcnt_q : tcnt_q + 16'h0001;

      // Register writes
      if (i_wr) begin
         case (i_addr)
            A_CTRL:  ctrl_d  = {i_wdata[B_FUNC], i_wdata[B_SCAN],
                                2'b00, i_wdata[B_CONT], i_wdata[B_ADV]};
            A_SRC:   src_d   = i_wdata[8:0];
            A_ARMN:  armn_d  = i_wdata[15:0];
            A_SCANN: scann_d = i_wdata[15:0];
            A_MEASN: measn_d = i_wdata[15:0];
            A_TIMER: tmr_d   = i_wdata[15:0];
            default: ;
         endcase
      end

      // Sequencer
      case (state_q)
         // Waits outside all layers
         ST_IDLE: begin
            if (i_manual_fire_key || i_bus_init || init_w) begin
               armed_d  = 1'b1;
               tfirst_d = 1'b1;
               state_d  = ctrl_d[B_ADV] ? ST_ARM : ST_MANUAL_FIRE_KEY;
            end
         end
         ST_ARM: begin
            if (hit) begin
               tfirst_d = 1'b1;
               state_d  = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (hit) begin
               state_d = ST_MANUAL_FIRE_KEY;
            end
         end
         ST_MANUAL_FIRE_KEY: begin
            if (!adv && ctrl_q[B_CONT]) begin
               state_d = ST_ACT;
            end else if (hit) begin
               state_d = ST_ACT;
            end
         end
         // Action entry: step the scanner first when enabled
         ST_ACT: begin
            if (ctrl_q[B_SCAN]) begin
               ropen_d = 1'b1;
               dly_d   = BREAK_CNT;
               state_d = ST_BRK;
            end else begin
               func_d   = ctrl_q[B_FUNC];
               mstart_d = 1'b1;
               state_d  = ST_MEAS;
            end
         end
         // Old channel is open; close the next only after the break
         ST_BRK: begin
            if (dly_q <= 16'h0001) begin
               rclose_d = 1'b1;
               chan_d   = chan_q + 4'h1;
               dly_d    = SETTLE_CNT;
               state_d  = ST_SETL;
            end else begin
               dly_d = dly_q - 16'h0001;
            end
         end
         // Relay settling counts as part of the action
         ST_SETL: begin
            if (dly_q <= 16'h0001) begin
               func_d   = ctrl_q[B_FUNC];
               mstart_d = 1'b1;
               state_d  = ST_MEAS;
            end else begin
               dly_d = dly_q - 16'h0001;
            end
         end
         ST_MEAS: begin
            if (i_meas_done) begin
               otrig_d = 1'b1;
               state_d = ST_OUT;
            end
         end
         // Layer counting; a limit of zero loops forever
         ST_OUT: begin
            if (!adv) begin
               state_d = ST_MANUAL_FIRE_KEY;
            end else if (measn_q == 16'h0000 ||
                         measc_q + 16'h0001 < measn_q) begin
               measc_d = measc_q + 16'h0001;
               state_d = ST_MANUAL_FIRE_KEY;
            end else begin
               measc_d = 16'h0000;
               if (scann_q == 16'h0000 ||
                   scanc_q + 16'h0001 < scann_q) begin
                  scanc_d = scanc_q + 16'h0001;
                  state_d = ST_SCAN;
               end else begin
                  scanc_d = 16'h0000;
                  if (armn_q == 16'h0000 ||
                      armc_q + 16'h0001 < armn_q) begin
                     armc_d  = armc_q + 16'h0001;
                     state_d = ST_ARM;
                  end else begin
                     armc_d  = 16'h0000;
                     armed_d = 1'b0;
                     state_d = ST_IDLE;
                  end
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase

      // A timer hit restarts the interval; the arm layer has no timer
      if (hit && cur_src == SRC_TIMER && (state_q == ST_SCAN || state_q == ST_MANUAL_FIRE_KEY)) begin
         tcnt_d   = 16'h0000;
         tfirst_d = 1'b0;
      end

      // Abort overrides the next state and armed flag and empties the layer counters
      if (abort_w) begin
         state_d = ST_IDLE;
         armed_d = 1'b0;
         armc_d  = 16'h0000;
         scanc_d = 16'h0000;
         measc_d = 16'h0000;
      end
   end

   // ==========================================
   // Read data, valid the cycle after the strobe
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            A_CTRL:  rdata_d = {26'h000_0000, ctrl_q};
            A_SRC:   rdata_d = {23'h00_0000, src_q};
            A_ARMN:  rdata_d = {16'h0000, armn_q};
            A_SCANN: rdata_d = {16'h0000, scann_q};
            A_MEASN: rdata_d = {16'h0000, measn_q};
            A_TIMER: rdata_d = {16'h0000, tmr_q};
            A_STAT:  rdata_d = {measc_q[11:0], chan_q, 11'h000,
                                armed_q, state_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // Registers; reset puts the bench default in place
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state_q  <= ST_ARM;
         armed_q  <= 1'b1;
         ctrl_q   <= CTRL_RST;
         src_q    <= SRC_RST;
         armn_q   <= CNT_RST;
         scann_q  <= CNT_RST;
         measn_q  <= CNT_RST;
         tmr_q    <= TIMER_RST;
         armc_q   <= 16'h0000;
         scanc_q  <= 16'h0000;
         measc_q  <= 16'h0000;
         tcnt_q   <= 16'h0000;
         tfirst_q <= 1'b1;
         dly_q    <= 16'h0000;
         chan_q   <= 4'h0;
         ropen_q  <= 1'b0;
         rclose_q <= 1'b0;
         func_q   <= 1'b0;
         mstart_q <= 1'b0;
         otrig_q  <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         state_q  <= state_d;
         armed_q  <= armed_d;
         ctrl_q   <= ctrl_d;
         src_q    <= src_d;
         armn_q   <= armn_d;
         scann_q  <= scann_d;
         measn_q  <= measn_d;
         tmr_q    <= tmr_d;
         armc_q   <= armc_d;
         scanc_q  <= scanc_d;
         measc_q  <= measc_d;
         tcnt_q   <= tcnt_d;
         tfirst_q <= tfirst_d;
         dly_q    <= dly_d;
         chan_q   <= chan_d;
         ropen_q  <= ropen_d;
         rclose_q <= rclose_d;
         func_q   <= func_d;
         mstart_q <= mstart_d;
         otrig_q  <= otrig_d;
         rdata_q  <= rdata_d;
      end
   end

   assign o_rdata       = rdata_q;
   assign o_armed       = armed_q;
   assign o_relay_open  = ropen_q;
   assign o_relay_close = rclose_q;
   assign o_channel     = chan_q;
   assign o_func_change = func_q;
   assign o_meas_start  = mstart_q;
   assign o_out_manual_fire_key    = otrig_q;

   // ==========================================
   // Checks
   logic opened_q;  // Open seen since last close
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         opened_q <= 1'b0;
      end else if (ropen_q) begin
         opened_q <= 1'b1;
      end else if (rclose_q) begin
         opened_q <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   a_idle_exit_key: assert property (
      state_q == ST_IDLE && i_manual_fire_key && !abort_w
      |=> armed_q && state_q != ST_IDLE)
      else $error("manual key did not leave idle");
   a_imm_arm_pass: assert property (
      state_q == ST_ARM && src_q[F_ARM +: 3] == 3'(SRC_IMM) && !abort_w
      |=> state_q == ST_SCAN)
      else $error("immediate source stalled");
   a_ext_wait: assert property (
      adv && state_q == ST_MANUAL_FIRE_KEY && cur_src == SRC_EXT
      && !i_external_fire_input && !abort_w |=> state_q == ST_MANUAL_FIRE_KEY)
      else $error("external source passed without pulse");
   a_hold_stalls: assert property (
      adv && state_q == ST_MANUAL_FIRE_KEY && cur_src == SRC_HOLD && !abort_w
      |=> state_q == ST_MANUAL_FIRE_KEY)
      else $error("hold source passed");
   a_link_basic: assert property (
      !adv && state_q == ST_MANUAL_FIRE_KEY && cur_src == SRC_LINK && !abort_w
      |=> state_q == ST_ACT)
      else $error("link source used in basic mode");
   a_cont_bypass: assert property (
      !adv && ctrl_q[B_CONT] && state_q == ST_MANUAL_FIRE_KEY && !abort_w
      |=> state_q == ST_ACT)
      else $error("continuous basic waited on source");
   a_break_make: assert property (disable iff (!i_resetn || abort_w)
      $rose(ropen_q) |-> ##1 !rclose_q [*8] ##[1:600] rclose_q)
      else $error("close not after break delay");
   a_close_open: assert property (
      rclose_q |-> opened_q)
      else $error("close without prior open");
   a_out_after: assert property (
      state_q == ST_MEAS && i_meas_done && !abort_w
      |=> otrig_q ##1 !otrig_q)
      else $error("output pulse missing or long");
   a_idle_clear: assert property (
      state_q == ST_IDLE |-> armc_q == 16'h0000
      && scanc_q == 16'h0000 && measc_q == 16'h0000)
      else $error("counter not cleared at idle");
   a_meas_loop: assert property (
      adv && state_q == ST_OUT && measn_q == 16'h0000 && !abort_w
      |=> state_q == ST_MANUAL_FIRE_KEY)
      else $error("infinite measure left layer");

   c_scan_step:  cover property (rclose_q ##[1:600] otrig_q);
   c_arm_done:   cover property (state_q == ST_OUT ##1 state_q == ST_IDLE);
   c_timer_wait: cover property (state_q == ST_MANUAL_FIRE_KEY && cur_src == SRC_TIMER
                                 && !hit);
endmodule : tms_sequencer

// [test/tms_meas_model.sv]
`timescale 1ns/1ps
// ==========================================
// Measurement engine stand-in: answers each start after a set delay
module tms_meas_model (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_meas_start,
   input  wire logic [7:0] i_delay,
   output logic            o_meas_done
);
   logic [7:0] cnt_q;  // Cycles left before done
   logic       busy_q; // A measurement is in flight

   // Done stands one cycle only, so a late look by the sequencer misses it
   always_ff @(posedge i_clk) begin
      o_meas_done <= 1'b0;
      if (!i_resetn) begin
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
      end else if (i_meas_start) begin
         busy_q <= 1'b1;
         cnt_q  <= i_delay;
      end else if (busy_q && cnt_q == 8'h00) begin
         busy_q      <= 1'b0;
         o_meas_done <= 1'b1;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule : tms_meas_model

// [test/tb_top.sv]
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the trigger sequencer
module tb_top
   import tms_pkg::*;
;
   logic        clk, rstn, wr, rd, key, binit, mdone;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  fire;   // Link, bus, manual, external trigger lines
   logic [3:0]  chan, ch0;
   logic        armed, ropen, rclose, func, mstart, otrig;
   logic [7:0]  dly;    // Partner answer delay
   int          miscompares, tests_run, cyc, n0, c0, t1, nn;
   int          n[5];   // Meas, open, close, out, func pulse counts
   int          t_meas, t_open, t_close;

   always #2 clk = ~clk;

   tms_sequencer u_dut (.i_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_manual_fire_key(key | fire[1]),
      .i_external_fire_input(fire[0]), .i_bus_trigger(fire[2]), .i_bus_init(binit),
      .i_link_bus_source(fire[3]), .i_meas_done(mdone), .o_armed(armed),
      .o_relay_open(ropen), .o_relay_close(rclose), .o_channel(chan),
      .o_func_change(func), .o_meas_start(mstart), .o_out_manual_fire_key(otrig));

   tms_meas_model u_meas (.i_clk(clk), .i_resetn(rstn), .i_meas_start(mstart),
      .i_delay(dly), .o_meas_done(mdone));

   // Pulse monitor; pulses stand one cycle so each edge is counted
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (mstart === 1'b1) begin
         n[0]   <= n[0] + 1;
         t_meas <= cyc;
      end
      if (ropen === 1'b1) begin
         n[1]   <= n[1] + 1;
         t_open <= cyc;
      end
      if (rclose === 1'b1) begin
         n[2]    <= n[2] + 1;
         t_close <= cyc;
      end
      if (otrig === 1'b1) n[3] <= n[3] + 1;
      if (func === 1'b1) n[4] <= n[4] + 1;
   end

   // ==========================================
   // Helpers
   task chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         miscompares++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask : chk

   task wr32(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr32

   // Data stand only in the cycle after the strobe
   task rd32(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd32

   // Bounded wait for a new pulse of kind k
   task wait_ev(input int k, input int lim);
      int s;
      s = n[k];
      for (int i = 0; i < lim && n[k] == s; i++) @(posedge clk);
      #1 chk(n[k] != s, "expected pulse missing");
   endtask : wait_ev

   task pulse(input logic [3:0] f);
      @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= 4'h0;
   endtask : pulse

   // Source field for the measure layer
   function automatic logic [31:0] manual_fire_key_src(input tms_src_e s);
      return 32'(s) << F_MANUAL_FIRE_KEY;
   endfunction : manual_fire_key_src

   // Stop, reconfigure, start again
   task restart(input logic [31:0] ctl, input logic [31:0] src, input logic [31:0] cnt);
      wr32(A_CTRL, ctl | 32'h0000_0008);
      wr32(A_SRC, src);
      wr32(A_ARMN, cnt);
      wr32(A_SCANN, cnt);
      wr32(A_MEASN, 32'h0000_0000);
      wr32(A_CTRL, ctl | 32'h0000_0004);
      dly <= 8'($urandom % 8 + 1);
   endtask : restart

   task done_t(input string s);
      $display("Test %s finished, mismatches so far %0d", s, miscompares);
   endtask : done_t

   task wrap_up;
      $display("Checks made %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // Watchdog: the tests need well under 20000 cycles
   initial begin
      #80_000;
      miscompares++;
      wrap_up();
   end

   // ==========================================
   // Main sequence
   initial begin
      clk = 0; rstn = 0; wr = 0; rd = 0; key = 0; binit = 0; fire = 4'h0;
      addr = 5'h00; wdata = 32'h0000_0000; dly = 8'h03; cyc = 0;
      foreach (n[i]) n[i] = 0;
      void'($urandom(14828));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      // Defaults: advanced, running, immediate, infinite
      rd32(A_CTRL, v); chk(v === 32'h0000_0001, "ctrl default");
      rd32(A_SRC, v); chk(v === 32'h0000_0000, "sources default");
      rd32(A_MEASN, v); chk(v === 32'h0000_0000, "measure count default");
      rd32(A_TIMER, v); chk(v === {16'h0000, TIMER_RST}, "timer default");
      rd32(5'h1C, v); chk(v === 32'h0000_0000, "unmapped read");
      chk(armed === 1'b1, "armed after reset");
      for (int i = 0; i < 3; i++) begin
         wait_ev(0, 100);
         wait_ev(3, 100);
      end
      done_t("defaults");
      // Abort to idle, stray triggers dropped, bus initiate restarts
      wr32(A_CTRL, 32'h0000_0009);
      repeat (2) @(posedge clk);
      chk(armed === 1'b0, "armed in idle");
      n0 = n[0];
      pulse(4'hD);
      repeat (60) @(posedge clk);
      chk(n[0] == n0, "measured while idle");
      @(posedge clk) binit <= 1'b1;
      @(posedge clk) binit <= 1'b0;
      wait_ev(0, 40);
      chk(armed === 1'b1, "armed after initiate");
      wr32(A_CTRL, 32'h0000_0009);
      @(posedge clk) key <= 1'b1;
      @(posedge clk) key <= 1'b0;
      wait_ev(0, 40);
      done_t("idle");
      // Each waiting source but immediate and the timer stalls until its own line fires; hold never
      for (int s = 1; s < 7; s++) begin
         if (s == 5) continue;
         restart(32'h0000_0001, manual_fire_key_src(tms_src_e'(s)), 32'h0000_0000);
         n0 = n[0];
         repeat (40) @(posedge clk);
         chk(n[0] == n0, "source did not stall");
         pulse(s == 6 ? 4'hF : 4'(1 << (s - 1)));
         if (s == 6) begin
            repeat (40) @(posedge clk);
            chk(n[0] == n0, "hold passed");
         end else begin
            wait_ev(0, 20);
         end
      end
      done_t("sources");
      // Timer: first pass at once, next after the interval
      wr32(A_TIMER, 32'h0000_0028);
      restart(32'h0000_0001, manual_fire_key_src(SRC_TIMER), 32'h0000_0000);
      wait_ev(0, 30);
      t1 = t_meas;
      wait_ev(0, 200);
      chk(t_meas - t1 >= 40 && t_meas - t1 <= 40 + 30, "timer interval");
      done_t("timer");
      // Finite measure count ends in idle; counter cleared for a rerun
      nn = 2 + $urandom % 4;
      restart(32'h0000_0001, 32'h0000_0000, 32'h0000_0001);
      wr32(A_CTRL, 32'h0000_0009);
      wr32(A_MEASN, 32'(nn));
      for (int r = 0; r < 2; r++) begin
         n0 = n[0];
         wr32(A_CTRL, 32'h0000_0005);
         repeat (300) @(posedge clk);
         chk(n[0] - n0 == nn, "finite pass count");
         chk(armed === 1'b0, "not idle after count");
      end
      done_t("counts");
      // Scan: break before make, settle, then function change and measure start together
      wr32(A_MEASN, 32'h0000_0001);
      c0 = n[2];
      ch0 = chan;
      n0 = n[4];
      wr32(A_CTRL, 32'h0000_0035);
      wait_ev(1, 40);
      chk(n[2] == c0, "close before open");
      wait_ev(2, 300);
      chk(t_close - t_open == BREAK_CYC, "break time");
      chk(chan === ch0 + 4'h1, "channel step");
      wait_ev(0, 600);
      chk(t_meas - t_close == SETTLE_CYC, "settle time");
      chk(n[4] != n0, "function change missing");
      wait_ev(3, 40);
      // Single pass on every layer: back in idle, counters empty, new channel shown
      rd32(A_STAT, v);
      chk(v === {12'h000, 4'(ch0 + 4'h1), 16'h0000}, "status after scan");
      done_t("scan");
      // Basic continuous skips hold; basic one-shot treats link as immediate
      restart(32'h0000_0002, manual_fire_key_src(SRC_HOLD), 32'h0000_0000);
      wait_ev(0, 40);
      wait_ev(0, 60);
      restart(32'h0000_0000, manual_fire_key_src(SRC_LINK), 32'h0000_0000);
      wait_ev(0, 40);
      done_t("basic");
      wrap_up();
   end
endmodule : tb_top
